// file: hdl/sac_conv.sv
// Successive approximation conversion control with serial readout
`include "sac_map.svh"
module sac_conv import sac_pkg::*; #(
  parameter int BITS = `SAC_RESULT_BITS,
  parameter int INT_DIV = `SAC_INT_CLK_DIV,
  parameter int EXT_IDLE = `SAC_EXT_IDLE_CYC,
  parameter int DEPTH = `SAC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic conversion_start_n,
  input wire logic read_n,
  input wire logic power_down_n,
  input wire logic external_conv_clock_in,
  input wire logic shift_clock,
  input wire logic comparator_in,
  output logic busy_n,
  output logic conv_clock_out,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  output logic sampling,
  output logic nap,
  output logic sleep,
  output logic overflow
);
  localparam int DW = (INT_DIV > 1) ? $clog2(INT_DIV) : 1;
  localparam int IW = $clog2(EXT_IDLE + 1);
  localparam int BW = $clog2(BITS + 1);
  sac_conv_e state;
  sac_power_e power;
  logic start_s;
  logic rd_s;
  logic pd_s;
  logic ext_s;
  logic sclk_s;
  logic start_q;
  logic pd_q;
  logic ext_q;
  logic sclk_q;
  logic [DW-1:0] div_cnt;
  logic int_tick;
  logic [IW-1:0] ext_idle;
  logic use_internal;
  logic step;
  logic [BITS-1:0] approx;
  logic [BITS-1:0] trial;
  logic [BW-1:0] bit_idx;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  sac_word_s fifo_in;
  sac_word_s fifo_out;
  logic [BITS-1:0] shreg;
  logic [BW-1:0] shift_left;
  logic start_fall;
  logic sclk_fall;

  initial begin
    if (BITS != 14 || INT_DIV < 1 || EXT_IDLE < 2 || DEPTH < 2) begin
      $error("sac_conv parameters out of range");
    end
  end

  sac_sync u_sync_start (.clk(clk), .rstn(rstn), .async_in(conversion_start_n), .reset_level(1'b1),
    .sync_out(start_s));
  sac_sync u_sync_rd (.clk(clk), .rstn(rstn), .async_in(read_n), .reset_level(1'b1), .sync_out(rd_s));
  sac_sync u_sync_pd (.clk(clk), .rstn(rstn), .async_in(power_down_n), .reset_level(1'b1),
    .sync_out(pd_s));
  sac_sync u_sync_ext (.clk(clk), .rstn(rstn), .async_in(external_conv_clock_in), .reset_level(1'b1),
    .sync_out(ext_s));
  sac_sync u_sync_sclk (.clk(clk), .rstn(rstn), .async_in(shift_clock), .reset_level(1'b1),
    .sync_out(sclk_s));

  // Edge history of the cleaned inputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= 1'b1;
      pd_q <= 1'b1;
      ext_q <= 1'b1;
      sclk_q <= 1'b1;
    end else begin
      start_q <= start_s;
      pd_q <= pd_s;
      ext_q <= ext_s;
      sclk_q <= sclk_s;
    end
  end
  assign start_fall = start_q && !start_s;
  assign sclk_fall = sclk_q && !sclk_s;

  // Power-down mode captured on the power-down falling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power <= SAC_ACTIVE;
    end else if (pd_s) begin
      power <= SAC_ACTIVE;
    end else if (pd_q) begin
      power <= rd_s ? SAC_SLEEP : SAC_NAP;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nap <= 1'b0;
      sleep <= 1'b0;
    end else begin
      nap <= (power == SAC_NAP);
      sleep <= (power == SAC_SLEEP);
    end
  end

  // Input held high with no edges selects the internal clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_idle <= '0;
      use_internal <= 1'b1;
    end else if (!ext_s || (ext_s && !ext_q)) begin
      ext_idle <= '0;
      use_internal <= 1'b0;
    end else if (ext_idle == IW'(EXT_IDLE)) begin
      use_internal <= 1'b1;
    end else begin
      ext_idle <= ext_idle + 1'b1;
    end
  end

  // Internal conversion clock from divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= '0;
    end else if (div_cnt == DW'(INT_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign int_tick = (div_cnt == DW'(INT_DIV - 1));
  assign step = use_internal ? int_tick : (ext_s && !ext_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_clock_out <= 1'b0;
    end else if (use_internal) begin
      conv_clock_out <= (div_cnt < DW'((INT_DIV + 1) / 2)) ^ (INT_DIV == 1 ? div_cnt[0] : 1'b0);
    end else begin
      conv_clock_out <= ext_s;
    end
  end

  // Conversion sequence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= SAC_ACQUIRE;
      approx <= `SAC_RESULT_RESET;
      trial <= '0;
      bit_idx <= '0;
    end else begin
      unique case (state)
        SAC_ACQUIRE: begin
          if (start_fall && power == SAC_ACTIVE) begin
            state <= SAC_CLEAR;
          end
        end
        SAC_CLEAR: begin
          approx <= '0;
          trial <= {1'b1, {(BITS - 1){1'b0}}};
          bit_idx <= BW'(BITS);
          state <= SAC_DECIDE;
        end
        SAC_DECIDE: begin
          if (step) begin
            if (comparator_in) begin
              approx <= approx | trial;
            end
            trial <= trial >> 1;
            bit_idx <= bit_idx - 1'b1;
            if (bit_idx == BW'(1)) begin
              state <= SAC_DONE;
            end
          end
        end
        SAC_DONE: begin
          if (fifo_in_ready) begin
            state <= SAC_ACQUIRE;
          end
        end
      endcase
    end
  end

  // Busy rises only after the word has entered the FIFO
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_n <= 1'b1;
      sampling <= 1'b1;
    end else begin
      busy_n <= (state == SAC_ACQUIRE) && !(start_fall && power == SAC_ACTIVE);
      sampling <= (state == SAC_ACQUIRE) && !(start_fall && power == SAC_ACTIVE);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflow <= 1'b0;
    end else if (state == SAC_DONE && !fifo_in_ready) begin
      overflow <= 1'b1;
    end else if (state == SAC_ACQUIRE) begin
      overflow <= 1'b0;
    end
  end

  assign fifo_in.code = approx;

  sac_fifo #(.WIDTH(BITS), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(state == SAC_DONE),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // Serial readout: load a word when idle and read is low
  assign fifo_out_ready = (shift_left == '0) && !rd_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shreg <= '0;
      shift_left <= '0;
      serial_data_out <= 1'b0;
    end else if (fifo_out_ready && fifo_out_valid) begin
      shreg <= fifo_out.code;
      shift_left <= BW'(BITS);
      serial_data_out <= fifo_out.code[BITS-1];
    end else if (sclk_fall && shift_left != '0) begin
      shreg <= {shreg[BITS-2:0], 1'b0};
      shift_left <= shift_left - 1'b1;
      serial_data_out <= shreg[BITS-2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_data_oe_n <= 1'b1;
    end else begin
      serial_data_oe_n <= rd_s;
    end
  end
endmodule : sac_conv

// file: hdl/sac_fifo.sv
// Result FIFO between conversion and serial readout
module sac_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sac_fifo depth must be a power of two");
    end
  end
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : sac_fifo

// file: hdl/sac_map.svh
// Offsets-free constant header: result width, reset values and timing counts
// Behaviour
// - A falling edge on conversion start begins a new conversion.
// - Busy stays low during a conversion and high otherwise.
// - Power-down low with read low enters nap.
// - Power-down low with read high enters sleep.
// - Nap or sleep is chosen by read level at power-down falling edge.
// - Serial output is driven only while read is asserted.
// - External clock input held high selects the internal conversion clock.
// - Approximation register is cleared before the first bit decision.
// - Start requests during a conversion are ignored.
// - The result resolves one bit per step, MSB to LSB.
// - The finished result leaves through the single serial data pin.
// - Acquisition begins once the finished word has entered the FIFO.
// - Serial output updates after each shift clock falling edge.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_RESULT_BITS 14
`define SAC_CLK_HZ 40000000
`define SAC_INT_CLK_DIV 2
`define SAC_EXT_IDLE_NS 2000
`define SAC_EXT_IDLE_CYC ((`SAC_EXT_IDLE_NS * (`SAC_CLK_HZ / 1000000)) / 1000)
`define SAC_RESULT_RESET 14'h0000
`define SAC_FIFO_DEPTH 16
`endif

// file: hdl/sac_pkg.sv
// Types shared by the conversion control block
package sac_pkg;
  typedef enum logic [3:0] {
    SAC_ACQUIRE = 4'h1,
    SAC_CLEAR = 4'h2,
    SAC_DECIDE = 4'h4,
    SAC_DONE = 4'h8
  } sac_conv_e;
  typedef enum logic [2:0] {
    SAC_ACTIVE = 3'h1,
    SAC_NAP = 3'h2,
    SAC_SLEEP = 3'h4
  } sac_power_e;
  typedef struct packed {
    logic [13:0] code;
  } sac_word_s;
endpackage : sac_pkg

// file: hdl/sac_sync.sv
// Three-stage synchroniser with agreement on the last two stages
module sac_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic async_in,
  input wire logic reset_level,
  output logic sync_out
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_out <= 1'b1;
    end else if (s2 == s3) begin
      sync_out <= s3;
    end
  end
endmodule : sac_sync

// file: tb/sac_conv_chk.sv
// Port-level checker for the conversion control block
module sac_conv_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic conversion_start_n,
  input wire logic read_n,
  input wire logic power_down_n,
  input wire logic busy_n,
  input wire logic serial_data_oe_n,
  input wire logic sampling,
  input wire logic nap,
  input wire logic sleep,
  input wire logic overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_start_takes_busy: assert property ($fell(conversion_start_n) && busy_n && sampling && !nap && !sleep |-> ##[3:8] !busy_n)
    else $error("start not taken");
  a_busy_min_span: assert property ($fell(busy_n) |-> !busy_n [*8])
    else $error("busy released early");
  a_busy_max_span: assert property ($fell(busy_n) |-> ##[20:1000] busy_n)
    else $error("busy stuck low");
  a_acquire_after: assert property ($rose(busy_n) |-> sampling)
    else $error("no acquire after conversion");
  a_acquire_off: assert property (!busy_n |-> !sampling)
    else $error("acquiring while busy");
  a_drive_off: assert property (read_n [*8] |-> serial_data_oe_n)
    else $error("output driven without read");
  a_drive_on: assert property (!read_n [*8] |-> !serial_data_oe_n)
    else $error("output not driven during read");
  a_nap_pick: assert property ($rose(nap) |-> !read_n && !power_down_n && !sleep)
    else $error("nap entered wrongly");
  a_sleep_pick: assert property ($rose(sleep) |-> read_n && !power_down_n && !nap)
    else $error("sleep entered wrongly");
  a_overflow_holds: assert property (overflow |-> !busy_n)
    else $error("busy high with word pending");
  c_done: cover property ($rose(busy_n));
  c_nap: cover property ($rose(nap));
  c_sleep: cover property ($rose(sleep));
  c_overflow: cover property ($rose(overflow));
endmodule : sac_conv_chk

bind sac_conv sac_conv_chk chk_u (.clk(clk), .rstn(rstn), .conversion_start_n(conversion_start_n),
  .read_n(read_n), .power_down_n(power_down_n), .busy_n(busy_n), .serial_data_oe_n(serial_data_oe_n),
  .sampling(sampling), .nap(nap), .sleep(sleep), .overflow(overflow));

// file: tb/sac_host.sv
// Host model: runs the shift clock and captures serial words
module sac_host (
  input wire logic clk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  output logic shift_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dline;
  initial shift_clock = 1'b1;
  // Released line reads back the inverse of the pin
  assign dline = serial_data_oe_n ? ~serial_data_out : serial_data_out;
  task automatic read_word(output logic [13:0] w);
    repeat (8) @(negedge clk);
    for (int i = 13; i >= 0; i--) begin
      w[i] = dline;
      shift_clock = 1'b0;
      repeat (4) @(negedge clk);
      shift_clock = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask : read_word
endmodule : sac_host

// file: tb/testbench.sv
// Self-checking bench for the conversion control block
module testbench import sac_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_SPAN = $bits(sac_word_s) * 2;
  logic clk = 1'b0, rstn = 1'b0, conversion_start_n = 1'b1, read_n = 1'b0, power_down_n = 1'b1;
  logic external_conv_clock_in = 1'b1, comparator_in = 1'b0, ext_run = 1'b0;
  logic shift_clock, busy_n, conv_clock_out, serial_data_out, serial_data_oe_n, sampling, nap, sleep, overflow;
  int fail_count = 0, cmp_count = 0, ext_cnt = 0;
  sac_word_s got, exp_q[$];
  always #12.5 clk = ~clk;
  // Link clock of 200 ns runs only during external-clock frames
  always @(negedge clk) begin
    ext_cnt <= ext_cnt + 1;
    if (!ext_run) external_conv_clock_in <= 1'b1;
    else if (ext_cnt % 4 == 0) external_conv_clock_in <= ~external_conv_clock_in;
  end
  sac_conv #(.EXT_IDLE(6)) dut_u (.clk(clk), .rstn(rstn), .conversion_start_n(conversion_start_n),
    .read_n(read_n), .power_down_n(power_down_n), .external_conv_clock_in(external_conv_clock_in),
    .shift_clock(shift_clock), .comparator_in(comparator_in), .busy_n(busy_n), .conv_clock_out(conv_clock_out),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n), .sampling(sampling), .nap(nap),
    .sleep(sleep), .overflow(overflow));
  sac_host host_u (.clk(clk), .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .shift_clock(shift_clock));
  function automatic sac_word_s exp_word(input logic c);
    return c ? 14'h3FFF : 14'h0000;
  endfunction : exp_word
  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic give_up(input string what);
    fail_count++;
    $display("MISMATCH %s expected done seen timeout", what);
    final_report();
  endtask : give_up
  task automatic cmp(input string what, input logic [13:0] exp, input logic [13:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp
  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp_bit
  task automatic convert(input logic c, input bit again, input bit wait_done, output int dur);
    comparator_in = c;
    conversion_start_n = 1'b0;
    dur = 0;
    repeat (3) @(negedge clk);
    conversion_start_n = 1'b1;
    for (int i = 0; busy_n !== 1'b0; i++) begin
      if (i == 20) give_up("busy_n fall");
      @(negedge clk);
    end
    while (busy_n === 1'b0 && dur < (wait_done ? 600 : 40)) begin
      @(negedge clk);
      dur++;
      if (again) conversion_start_n = (dur < 4 || dur > 8);
    end
    if (wait_done && dur >= 600) give_up("busy_n rise");
    repeat (70) @(negedge clk);
  endtask : convert
  initial begin
    int dur;
    logic c;
    logic ck;
    c = $urandom(32'hD120);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      c = $urandom_range(1, 0);
      convert(c, k == 1, 1'b1, dur);
      cmp_bit("busy span", 1'b1, dur >= MIN_SPAN);
      cmp_bit("sampling", 1'b1, sampling);
      host_u.read_word(got);
      cmp("word", exp_word(c), got);
    end
    ck = conv_clock_out;
    @(negedge clk);
    cmp_bit("clock echo", ~ck, conv_clock_out);
    ext_run = 1'b1;
    repeat (10) @(negedge clk);
    convert(1'b1, 1'b0, 1'b1, dur);
    ext_run = 1'b0;
    cmp_bit("ext span", 1'b1, dur >= 13 * 8);
    host_u.read_word(got);
    cmp("ext word", 14'h3FFF, got);
    for (int m = 0; m < 2; m++) begin
      read_n = m[0];
      repeat (8) @(negedge clk);
      power_down_n = 1'b0;
      repeat (10) @(negedge clk);
      read_n = ~m[0];
      conversion_start_n = 1'b0;
      repeat (10) @(negedge clk);
      cmp_bit("nap", ~m[0], nap);
      cmp_bit("sleep", m[0], sleep);
      cmp_bit("busy in power-down", 1'b1, busy_n);
      conversion_start_n = 1'b1;
      power_down_n = 1'b1;
      repeat (20) @(negedge clk);
    end
    read_n = 1'b1;
    repeat (10) @(negedge clk);
    for (int k = 0; k < 17; k++) begin
      c = $urandom_range(1, 0);
      exp_q.push_back(exp_word(c));
      convert(c, 1'b0, k < 16, dur);
    end
    cmp_bit("overflow", 1'b1, overflow);
    cmp_bit("oe off", 1'b1, serial_data_oe_n);
    read_n = 1'b0;
    foreach (exp_q[i]) begin
      host_u.read_word(got);
      cmp("queued word", exp_q[i], got);
    end
    cmp_bit("overflow gone", 1'b0, overflow);
    final_report();
  end
endmodule : testbench
